/* rtl/avsr_pkg.sv */
// Shared constants and types for the verify, seek and recalibrate command logic
package avsr_pkg;

  // Task-file register addresses
  localparam logic [9:0] REG_DATA = 10'h1f0;
  localparam logic [9:0] REG_FAULT = 10'h1f1;
  localparam logic [9:0] REG_COUNT = 10'h1f2;
  localparam logic [9:0] REG_SECNUM = 10'h1f3;
  localparam logic [9:0] REG_CYL_LO = 10'h1f4;
  localparam logic [9:0] REG_CYL_HI = 10'h1f5;
  localparam logic [9:0] REG_DRVHEAD = 10'h1f6;
  localparam logic [9:0] REG_OPCODE = 10'h1f7;

  // Command codes
  localparam logic [7:0] OPC_WRITE_VERIFY = 8'h3c;
  localparam logic [3:0] OPC_RECAL_HI = 4'h1;
  localparam logic [3:0] OPC_SEEK_HI = 4'h7;

  // Status bit positions
  localparam int STAT_BUSY = 7;
  localparam int STAT_READY = 6;
  localparam int STAT_SEEK_DONE = 4;
  localparam int STAT_DRQ = 3;
  localparam int STAT_ERR = 0;

  // Drive-head bit positions
  localparam int DRV_LBA = 6;
  localparam int DRV_DEV = 4;

  // Fault codes
  localparam logic [7:0] FAULT_ABORT = 8'h04;
  localparam logic [7:0] FAULT_NONE = 8'h00;

  // Reset values
  localparam logic [7:0] RST_COUNT = 8'h01;
  localparam logic [7:0] RST_SECNUM = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Geometry, transfer sizes and the divider's last step
  localparam logic [7:0] SECT_PER_TRACK = 8'h3f;
  localparam logic [7:0] HEAD_COUNT = 8'h10;
  localparam logic [7:0] WORD_LAST = 8'hff;
  localparam logic [4:0] DIV_LAST = 5'h1b;

  // Medium operations
  typedef enum logic [1:0] {
    MED_WRITE = 2'h0,
    MED_VERIFY = 2'h1,
    MED_SEEK = 2'h2,
    MED_RECAL = 2'h3
  } avsr_med_e;

  // Command sequencer states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DRQ = 6'h02,
    S_CONV1 = 6'h04,
    S_CONV2 = 6'h08,
    S_WRITE = 6'h10,
    S_VERIFY = 6'h20
  } avsr_state_e;

endpackage

/* rtl/avsr_div_if.sv */
// Handshake between the sequencer and the address divider
`timescale 1ns/1ps
`default_nettype none
interface avsr_div_if;
  logic start;
  logic [27:0] dividend;
  logic [7:0] divisor;
  logic done;
  logic [27:0] quotient;
  logic [7:0] remainder;

  modport master (
    output start, dividend, divisor,
    input done, quotient, remainder
  );
  modport unit (
    input start, dividend, divisor,
    output done, quotient, remainder
  );
endinterface
`default_nettype wire

/* rtl/avsr_divider.sv */
// Restoring divider used for block address to cylinder and head translation
`timescale 1ns/1ps
`default_nettype none
module avsr_divider
  import avsr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Divider port
  avsr_div_if.unit div
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] count;
    logic [27:0] quo;
    logic [7:0] rem;
    logic [7:0] dvs;
  } avsr_div_s;

  avsr_div_s s;
  avsr_div_s next_s;

  always_comb begin
    logic [8:0] tmp;
    logic [8:0] diff;
    tmp = {s.rem, s.quo[27]};
    diff = tmp - {1'b0, s.dvs};
    next_s = s;
    next_s.done = 1'b0;
    if (div.start) begin
      next_s.busy = 1'b1;
      next_s.count = 5'h00;
      next_s.quo = div.dividend;
      next_s.rem = 8'h00;
      next_s.dvs = div.divisor;
    end else if (s.busy) begin
      next_s.quo = {s.quo[26:0], 1'b0};
      if (tmp >= {1'b0, s.dvs}) begin
        next_s.rem = diff[7:0];
        next_s.quo[0] = 1'b1;
      end else begin
        next_s.rem = tmp[7:0];
      end
      next_s.count = s.count + 5'h01;
      if (s.count == DIV_LAST) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign div.done = s.done;
  assign div.quotient = s.quo;
  assign div.remainder = s.rem;

endmodule
`default_nettype wire

/* rtl/avsr_top.sv */
// Task-file command logic for write-with-verify, recalibrate and seek
// Operation
// - Opcode 3C starts write-with-verify, run as a normal sector write.
// - Each sector is verified right after it is written, before the next.
// - Verify reads back and checks internally; no data goes to the host.
// - Verify errors are posted in status and fault registers at command end.
// - On error end, sector count holds sectors not yet transferred.
// - At write-verify end drive-head holds mode, device bit, end head or LBA top.
// - Any opcode 1x is recalibrate; the low nibble is ignored.
// - Recalibrate sets busy, then calibrates the positioner.
// - After calibration, refresh status, clear busy, raise interrupt.
// - Recalibrate is accepted in block-address mode too.
// - Any opcode 7x is seek; the low nibble is ignored.
// - Seek moves to the cylinder registers' track and drive-head's head.
// - After seek completes, clear busy and raise interrupt.
// - The seek-complete status flag always reads 1.
// - In block-address mode seek translates the block address to cylinder/head.
// - At seek end drive-head returns mode, device bit, head or LBA top.
// - An error ending a command interrupts and leaves valid fault information.
`timescale 1ns/1ps
`default_nettype none
module avsr_top
  import avsr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host task-file port
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic intrq,
  // Medium and positioner port
  output logic med_req,
  output logic [1:0] med_op,
  output logic [15:0] med_cyl,
  output logic [3:0] med_head,
  output logic [7:0] med_sector,
  output logic [15:0] med_wdata,
  output logic med_wvalid,
  input wire logic med_done,
  input wire logic med_err,
  input wire logic [7:0] med_err_code
);

  typedef struct packed {
    avsr_state_e fsm;
    logic [7:0] fault_info;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] cylinder_low;
    logic [7:0] cylinder_high;
    logic [7:0] drive_head;
    logic busy;
    logic drq;
    logic err;
    logic intrq;
    logic is_seek;
    logic positioning;
    logic [7:0] word_cnt;
    logic [7:0] rdata;
    logic med_req;
    avsr_med_e med_op;
    logic [15:0] med_cyl;
    logic [3:0] med_head;
    logic [7:0] med_sector;
    logic [15:0] med_wdata;
    logic med_wvalid;
    logic div_start;
    logic [27:0] div_dividend;
    logic [7:0] div_divisor;
  } avsr_top_s;

  avsr_top_s s;
  avsr_top_s next_s;
  avsr_div_if div ();

  avsr_divider u_divider (
    .clk(clk),
    .rst_n(rst_n),
    .div(div)
  );

  assign div.start = s.div_start;
  assign div.dividend = s.div_dividend;
  assign div.divisor = s.div_divisor;

  always_comb begin
    logic [27:0] lba;
    logic [27:0] lba_next;
    logic [7:0] status;
    logic [7:0] count_left;
    logic host_wr;
    logic lba_mode;
    lba = {s.drive_head[3:0], s.cylinder_high, s.cylinder_low, s.sector_number};
    lba_next = lba + 28'h000_0001;
    count_left = s.sector_count - 8'h01;
    host_wr = reg_cs && reg_wr;
    lba_mode = s.drive_head[DRV_LBA];
    status = 8'h00;
    status[STAT_BUSY] = s.busy;
    status[STAT_READY] = 1'b1;
    status[STAT_SEEK_DONE] = 1'b1;
    status[STAT_DRQ] = s.drq;
    status[STAT_ERR] = s.err;

    next_s = s;
    next_s.med_wvalid = 1'b0;
    next_s.div_start = 1'b0;

    // Host reads; status read clears the interrupt
    if (reg_cs && reg_rd) begin
      case (reg_addr)
        REG_FAULT: next_s.rdata = s.fault_info;
        REG_COUNT: next_s.rdata = s.sector_count;
        REG_SECNUM: next_s.rdata = s.sector_number;
        REG_CYL_LO: next_s.rdata = s.cylinder_low;
        REG_CYL_HI: next_s.rdata = s.cylinder_high;
        REG_DRVHEAD: next_s.rdata = s.drive_head;
        REG_OPCODE: begin
          next_s.rdata = status;
          next_s.intrq = 1'b0;
        end
        default: next_s.rdata = 8'h00;
      endcase
    end

    // Host writes to the task file while idle
    if (host_wr && !s.busy && !s.drq) begin
      case (reg_addr)
        REG_COUNT: next_s.sector_count = reg_wdata[7:0];
        REG_SECNUM: next_s.sector_number = reg_wdata[7:0];
        REG_CYL_LO: next_s.cylinder_low = reg_wdata[7:0];
        REG_CYL_HI: next_s.cylinder_high = reg_wdata[7:0];
        REG_DRVHEAD: next_s.drive_head = reg_wdata[7:0];
        REG_OPCODE: begin
          next_s.intrq = 1'b0;
          next_s.err = 1'b0;
          next_s.fault_info = FAULT_NONE;
          if (reg_wdata[7:0] == OPC_WRITE_VERIFY) begin
            // Plain sector write sequence, one sector per data phase
            next_s.is_seek = 1'b0;
            next_s.drq = 1'b1;
            next_s.word_cnt = 8'h00;
            next_s.fsm = S_DRQ;
          end else if (reg_wdata[7:4] == OPC_RECAL_HI) begin
            // Addressing mode is not looked at here
            next_s.busy = 1'b1;
            next_s.positioning = 1'b1;
            next_s.med_req = 1'b1;
            next_s.med_op = MED_RECAL;
          end else if (reg_wdata[7:4] == OPC_SEEK_HI) begin
            next_s.busy = 1'b1;
            next_s.is_seek = 1'b1;
            if (lba_mode) begin
              next_s.div_start = 1'b1;
              next_s.div_dividend = lba;
              next_s.div_divisor = SECT_PER_TRACK;
              next_s.fsm = S_CONV1;
            end else begin
              next_s.positioning = 1'b1;
              next_s.med_req = 1'b1;
              next_s.med_op = MED_SEEK;
              next_s.med_cyl = {s.cylinder_high, s.cylinder_low};
              next_s.med_head = s.drive_head[3:0];
              next_s.med_sector = s.sector_number;
            end
          end else begin
            // Unknown opcode aborts at once
            next_s.err = 1'b1;
            next_s.fault_info = FAULT_ABORT;
            next_s.intrq = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Recalibrate and seek completion
    if (s.positioning && med_done) begin
      next_s.positioning = 1'b0;
      next_s.med_req = 1'b0;
      next_s.busy = 1'b0;
      next_s.intrq = 1'b1;
      if (med_err) begin
        next_s.err = 1'b1;
        next_s.fault_info = med_err_code;
      end
    end

    case (s.fsm)
      S_IDLE: ;
      S_DRQ: begin
        // Sector words go straight to the medium
        if (host_wr && reg_addr == REG_DATA) begin
          next_s.med_wdata = reg_wdata;
          next_s.med_wvalid = 1'b1;
          next_s.word_cnt = s.word_cnt + 8'h01;
          if (s.word_cnt == WORD_LAST) begin
            next_s.drq = 1'b0;
            next_s.busy = 1'b1;
            if (lba_mode) begin
              next_s.div_start = 1'b1;
              next_s.div_dividend = lba;
              next_s.div_divisor = SECT_PER_TRACK;
              next_s.fsm = S_CONV1;
            end else begin
              next_s.med_req = 1'b1;
              next_s.med_op = MED_WRITE;
              next_s.med_cyl = {s.cylinder_high, s.cylinder_low};
              next_s.med_head = s.drive_head[3:0];
              next_s.med_sector = s.sector_number;
              next_s.fsm = S_WRITE;
            end
          end
        end
      end
      S_CONV1: begin
        if (div.done) begin
          next_s.med_sector = div.remainder + 8'h01;
          next_s.div_start = 1'b1;
          next_s.div_dividend = div.quotient;
          next_s.div_divisor = HEAD_COUNT;
          next_s.fsm = S_CONV2;
        end
      end
      S_CONV2: begin
        if (div.done) begin
          next_s.med_cyl = div.quotient[15:0];
          next_s.med_head = div.remainder[3:0];
          next_s.med_req = 1'b1;
          if (s.is_seek) begin
            next_s.med_op = MED_SEEK;
            next_s.positioning = 1'b1;
            next_s.fsm = S_IDLE;
          end else begin
            next_s.med_op = MED_WRITE;
            next_s.fsm = S_WRITE;
          end
        end
      end
      S_WRITE: begin
        if (med_done) begin
          if (med_err) begin
            // Count keeps the failed sector and those after it
            next_s.med_req = 1'b0;
            next_s.busy = 1'b0;
            next_s.err = 1'b1;
            next_s.fault_info = med_err_code;
            next_s.intrq = 1'b1;
            next_s.fsm = S_IDLE;
          end else begin
            next_s.med_op = MED_VERIFY;
            next_s.fsm = S_VERIFY;
          end
        end
      end
      S_VERIFY: begin
        if (med_done) begin
          next_s.med_req = 1'b0;
          if (med_err) begin
            next_s.busy = 1'b0;
            next_s.err = 1'b1;
            next_s.fault_info = med_err_code;
            next_s.intrq = 1'b1;
            next_s.fsm = S_IDLE;
          end else if (count_left == 8'h00) begin
            // Address registers keep the last sector written
            next_s.sector_count = count_left;
            next_s.busy = 1'b0;
            next_s.intrq = 1'b1;
            next_s.fsm = S_IDLE;
          end else begin
            next_s.sector_count = count_left;
            if (lba_mode) begin
              next_s.sector_number = lba_next[7:0];
              next_s.cylinder_low = lba_next[15:8];
              next_s.cylinder_high = lba_next[23:16];
              next_s.drive_head[3:0] = lba_next[27:24];
            end else if (s.sector_number >= SECT_PER_TRACK) begin
              next_s.sector_number = RST_SECNUM;
              if ({4'h0, s.drive_head[3:0]} >= HEAD_COUNT - 8'h01) begin
                next_s.drive_head[3:0] = 4'h0;
                {next_s.cylinder_high, next_s.cylinder_low} =
                  {s.cylinder_high, s.cylinder_low} + 16'h0001;
              end else begin
                next_s.drive_head[3:0] = s.drive_head[3:0] + 4'h1;
              end
            end else begin
              next_s.sector_number = s.sector_number + 8'h01;
            end
            next_s.busy = 1'b0;
            next_s.drq = 1'b1;
            next_s.intrq = 1'b1;
            next_s.word_cnt = 8'h00;
            next_s.fsm = S_DRQ;
          end
        end
      end
      default: next_s.fsm = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.fsm <= S_IDLE;
      s.fault_info <= FAULT_NONE;
      s.sector_count <= RST_COUNT;
      s.sector_number <= RST_SECNUM;
      s.cylinder_low <= RST_ZERO;
      s.cylinder_high <= RST_ZERO;
      s.drive_head <= RST_ZERO;
      s.med_op <= MED_WRITE;
    end else begin
      s <= next_s;
    end
  end

  // Seek registers are left as positioned
  assign reg_rdata = s.rdata;
  assign intrq = s.intrq;
  assign med_req = s.med_req;
  assign med_op = s.med_op;
  assign med_cyl = s.med_cyl;
  assign med_head = s.med_head;
  assign med_sector = s.med_sector;
  assign med_wdata = s.med_wdata;
  assign med_wvalid = s.med_wvalid;

endmodule
`default_nettype wire

/* tb/avsr_monitor.sv */
// Concurrent checks on the command logic ports
`timescale 1ns/1ps
`default_nettype none
module avsr_monitor
  import avsr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host side
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic intrq,
  // Medium side
  input wire logic med_req,
  input wire logic [1:0] med_op,
  input wire logic [15:0] med_cyl,
  input wire logic med_wvalid,
  input wire logic med_done,
  input wire logic med_err
);
  logic idle;
  logic lba;
  logic cmd_wr;
  logic done_x;
  assign cmd_wr = reg_cs && reg_wr && reg_addr == REG_OPCODE && idle;
  assign done_x = med_req && med_done;
  // Tracks when a new command may be taken, except after a write-verify that ends without error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle <= 1'b1;
      lba <= 1'b0;
    end else begin
      if (cmd_wr && (reg_wdata[7:4] inside {OPC_RECAL_HI, OPC_SEEK_HI}
          || reg_wdata[7:0] == OPC_WRITE_VERIFY)) begin
        idle <= 1'b0;
      end else if (done_x && (med_err || med_op[1])) begin
        idle <= 1'b1;
      end
      if (idle && reg_cs && reg_wr && reg_addr == REG_DRVHEAD) begin
        lba <= reg_wdata[DRV_LBA];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_recal_starts: assert property (cmd_wr && reg_wdata[7:4] == OPC_RECAL_HI |=>
    med_req && med_op == MED_RECAL) else $error("recalibrate did not start");
  a_seek_chs: assert property (cmd_wr && reg_wdata[7:4] == OPC_SEEK_HI && !lba |=>
    med_req && med_op == MED_SEEK) else $error("seek did not start");
  a_seek_lba: assert property (cmd_wr && reg_wdata[7:4] == OPC_SEEK_HI && lba |->
    ##[1:100] med_req && med_op == MED_SEEK) else $error("block seek did not start");
  a_done_irq: assert property (done_x && med_op[1] |=> !med_req && intrq)
    else $error("positioner end without interrupt");
  a_verify_next: assert property (done_x && !med_err && med_op == MED_WRITE |=>
    med_req && med_op == MED_VERIFY) else $error("write not followed by verify");
  a_err_ends: assert property (done_x && med_err |=> !med_req && intrq)
    else $error("error end without interrupt");
  a_verify_quiet: assert property (med_req && med_op == MED_VERIFY |-> !med_wvalid)
    else $error("data moved during verify");
  a_req_holds: assert property (med_req && !med_done |=>
    med_req && $stable(med_op) && $stable(med_cyl)) else $error("medium request moved");
  c_recal: cover property (cmd_wr && reg_wdata[7:4] == OPC_RECAL_HI);
  c_seek_lba: cover property (cmd_wr && reg_wdata[7:4] == OPC_SEEK_HI && lba);
  c_verify_err: cover property (done_x && med_err && med_op == MED_VERIFY);
  c_write_err: cover property (done_x && med_err && med_op == MED_WRITE);
endmodule
bind avsr_top avsr_monitor u_mon (.clk(clk), .rst_n(rst_n), .reg_cs(reg_cs), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .intrq(intrq), .med_req(med_req),
  .med_op(med_op), .med_cyl(med_cyl), .med_wvalid(med_wvalid), .med_done(med_done),
  .med_err(med_err));
`default_nettype wire

/* tb/avsr_medium_model.sv */
// Behavioural medium and positioner answering the command logic
`timescale 1ns/1ps
`default_nettype none
module avsr_medium_model
  import avsr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the command logic
  input wire logic med_req,
  input wire logic [1:0] med_op,
  // Bench controls
  input wire logic [7:0] delay,
  input wire logic fail_en,
  input wire logic [1:0] fail_op,
  input wire logic [7:0] code,
  // Answer
  output logic med_done,
  output logic med_err,
  output logic [7:0] med_err_code
);
  logic armed;
  logic [7:0] cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {armed, cnt, med_done, med_err, med_err_code} <= '0;
    end else begin
      med_done <= 1'b0;
      // Error lines carry no meaning outside done
      med_err <= ~med_err;
      med_err_code <= ~med_err_code;
      if (med_req && !med_done && !armed) begin
        armed <= 1'b1;
        cnt <= delay;
      end else if (armed && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (armed) begin
        armed <= 1'b0;
        med_done <= 1'b1;
        med_err <= fail_en && med_op == fail_op;
        med_err_code <= code;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/ata_verify_seek_recal_cmds_test.sv */
// Self-checking bench for the verify, seek and recalibrate command logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ata_verify_seek_recal_cmds_test
  import avsr_pkg::*;
;
  logic clk, rst_n, reg_cs, reg_wr, reg_rd, intrq, med_req, med_wvalid, med_done, med_err;
  logic fail_en, rd_seen;
  logic [9:0] reg_addr;
  logic [15:0] reg_wdata, med_cyl, med_wdata, exp16;
  logic [7:0] reg_rdata, med_sector, med_err_code, dly, code, exp8;
  logic [3:0] med_head;
  logic [1:0] med_op, fail_op;
  logic [7:0] rq[$];
  logic [15:0] wq[$];
  logic [7:0] rv [7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h50};
  logic [31:0] lba;
  int err_count, n_tests;
  avsr_top u_dut (
    .clk(clk), .rst_n(rst_n), .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .intrq(intrq),
    .med_req(med_req), .med_op(med_op), .med_cyl(med_cyl), .med_head(med_head),
    .med_sector(med_sector), .med_wdata(med_wdata), .med_wvalid(med_wvalid),
    .med_done(med_done), .med_err(med_err), .med_err_code(med_err_code));
  avsr_medium_model u_med (
    .clk(clk), .rst_n(rst_n), .med_req(med_req), .med_op(med_op), .delay(dly),
    .fail_en(fail_en), .fail_op(fail_op), .code(code), .med_done(med_done),
    .med_err(med_err), .med_err_code(med_err_code));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Result watcher
  always @(posedge clk) rd_seen <= reg_cs & reg_rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      exp8 = rq.pop_front();
      `CHK(reg_rdata, exp8)
    end
    if (med_wvalid === 1'b1) begin
      exp16 = wq.pop_front();
      `CHK(med_wdata, exp16)
    end
  end
  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk);
    {reg_cs, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
    @(negedge clk);
    {reg_cs, reg_wr, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(negedge clk);
    {reg_cs, reg_rd, reg_addr} = {2'b11, a};
    rq.push_back(e);
    @(negedge clk);
    {reg_cs, reg_rd, reg_addr} = {2'b00, ~a};
  endtask
  task automatic ld(input logic [7:0] dh, ch, cl, sn, sc);
    wr(REG_DRVHEAD, {8'h00, dh});
    wr(REG_CYL_HI, {8'h00, ch});
    wr(REG_CYL_LO, {8'h00, cl});
    wr(REG_SECNUM, {8'h00, sn});
    wr(REG_COUNT, {8'h00, sc});
  endtask
  task automatic await(input logic [15:0] c, input logic [3:0] h, input logic [7:0] s);
    for (int i = 0; i < 200 && med_req !== 1'b1; i++) @(negedge clk);
    `CHK({med_req, med_cyl, med_head, med_sector}, {1'b1, c, h, s})
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 400 && intrq !== 1'b1; i++) @(negedge clk);
    `CHK(intrq, 1'b1)
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] c, input logic [3:0] h,
                     input logic [7:0] s, input logic [7:0] st);
    dly = 8'($urandom % 24);
    wr(REG_OPCODE, {8'h00, op});
    if (op[7:4] != OPC_RECAL_HI) await(c, h, s);
    wait_irq();
    rd(REG_OPCODE, st);
  endtask
  task automatic xfer;
    logic [15:0] w;
    repeat (256) begin
      w = 16'($urandom);
      wq.push_back(w);
      wr(REG_DATA, w);
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    {reg_cs, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {fail_en, fail_op, dly, code} = '0;
    {err_count, n_tests} = '0;
    rst_n = 1'b0;
    void'($urandom(63));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    foreach (rv[i]) rd(10'h1f1 + 10'(i), rv[i]);
    rd(10'h3ff, 8'h00);
    for (int n = 0; n < 16; n++) begin
      wr(REG_DRVHEAD, (n % 2) ? 16'h0040 : 16'h0000);
      cmd({OPC_RECAL_HI, 4'(n)}, '0, '0, '0, 8'h50);
    end
    wr(REG_OPCODE, 16'h00ec);
    wait_irq();
    rd(REG_OPCODE, 8'h51);
    rd(REG_FAULT, FAULT_ABORT);
    for (int n = 0; n < 16; n++) begin
      lba = $urandom;
      ld({4'h0, lba[19:16]}, lba[15:8], lba[7:0], lba[27:20], 8'h01);
      cmd({OPC_SEEK_HI, 4'(n)}, lba[15:0], lba[19:16], lba[27:20], 8'h50);
      rd(REG_DRVHEAD, {4'h0, lba[19:16]});
    end
    for (int k = 0; k < 4; k++) begin
      lba = $urandom % 32'h03f0_0000;
      code = 8'($urandom | 1);
      {fail_en, fail_op} = {k[0], k[1] ? MED_RECAL : MED_SEEK};
      ld({4'h4, lba[27:24]}, lba[23:16], lba[15:8], lba[7:0], 8'h01);
      cmd(k[1] ? 8'h1f : 8'h7f, 16'(lba / 1008), 4'(lba / 63 % 16), 8'(lba % 63 + 1),
          k[0] ? 8'h51 : 8'h50);
      rd(REG_DRVHEAD, {4'h4, lba[27:24]});
      rd(REG_FAULT, k[0] ? code : 8'h00);
    end
    fail_en = 1'b0;
    ld(8'h03, 8'h00, 8'h12, 8'h3f, 8'h02);
    wr(REG_OPCODE, {8'h00, OPC_WRITE_VERIFY});
    rd(REG_OPCODE, 8'h58);
    xfer();
    await(16'h0012, 4'h3, 8'h3f);
    wait_irq();
    rd(REG_OPCODE, 8'h58);
    rd(REG_SECNUM, 8'h01);
    rd(REG_DRVHEAD, 8'h04);
    rd(REG_COUNT, 8'h01);
    {fail_en, fail_op, code} = {1'b1, MED_VERIFY, 8'h5a};
    xfer();
    wait_irq();
    rd(REG_OPCODE, 8'h51);
    rd(REG_FAULT, 8'h5a);
    rd(REG_COUNT, 8'h01);
    rd(REG_DRVHEAD, 8'h04);
    fail_en = 1'b0;
    lba = $urandom % 32'h03f0_0000;
    ld({4'h4, lba[27:24]}, lba[23:16], lba[15:8], lba[7:0], 8'h01);
    wr(REG_OPCODE, {8'h00, OPC_WRITE_VERIFY});
    rd(REG_OPCODE, 8'h58);
    xfer();
    await(16'(lba / 1008), 4'(lba / 63 % 16), 8'(lba % 63 + 1));
    wait_irq();
    rd(REG_OPCODE, 8'h50);
    rd(REG_COUNT, 8'h00);
    rd(REG_DRVHEAD, {4'h4, lba[27:24]});
    {fail_en, fail_op, code} = {1'b1, MED_WRITE, 8'hc3};
    wr(REG_COUNT, 16'h0002);
    wr(REG_OPCODE, {8'h00, OPC_WRITE_VERIFY});
    xfer();
    wait_irq();
    rd(REG_OPCODE, 8'h51);
    rd(REG_FAULT, 8'hc3);
    rd(REG_COUNT, 8'h02);
    tally_and_finish();
  end
endmodule
`default_nettype wire
